// >>> design/intc_defines.svh
// offsets, field positions, reset values and counts of the interrupt unit
`ifndef INTC_DEFINES_SVH
`define INTC_DEFINES_SVH
`define IC_OFF_MASK 8'h00
`define IC_OFF_FLAG 8'h04
`define IC_OFF_FLAG_SET 8'h08
`define IC_OFF_FLAG_CLR 8'h0C
`define IC_OFF_MODE 8'h10
`define IC_OFF_STATUS 8'h14
`define IC_NSRC 7
`define IC_BIT_TIMER 3
`define IC_BIT_RX 4
`define IC_BIT_TX 5
`define IC_BIT_INT4 6
`define IC_MODE_BASE_LSB 11
`define IC_MODE_INTM_BIT 0
`define IC_MASK_RESET 7'h00
`define IC_BASE_RESET 5'h00
`define IC_SLOT_NMI 5'h11
`define IC_SLOT_FIRST 5'h01
`define IC_WAKE_NS 125
`define IC_CLK_NS 25
`define IC_WAKE_CYC ((`IC_WAKE_NS + `IC_CLK_NS - 1) / `IC_CLK_NS)
`define IC_STACK_DEPTH 8
`define IC_SHADOW_REGS 11
`define IC_RESP_OKAY 2'h0
`define IC_RESP_SLVERR 2'h2
`endif

// >>> design/intc_pkg.sv
// types shared by the interrupt and power-down unit
package intc_pkg;
  typedef enum logic [1:0] {ps_run, ps_idle, ps_deep, ps_hold} power_state_t;
endpackage

// >>> design/ret_stack.sv
// eight-entry return address stack, oldest entry lost on overflow
`timescale 1ns/1ps
`default_nettype none
`include "intc_defines.svh"
module ret_stack (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // stack operations
  input wire logic push,
  input wire logic pop,
  input wire logic [15:0] push_data,
  // state
  output logic [15:0] top,
  output logic [3:0] depth
);
  logic [15:0] mem_q [`IC_STACK_DEPTH];
  logic [15:0] mem_d [`IC_STACK_DEPTH];
  logic [2:0] ptr_q, ptr_d;
  logic [3:0] depth_q, depth_d;

  always_comb begin
    mem_d = mem_q;
    ptr_d = ptr_q;
    depth_d = depth_q;
    if (push) begin
      // circular pointer overwrites the oldest slot when full
      mem_d[ptr_q] = push_data; // R9 R20
      ptr_d = ptr_q + 3'h1;
      if (depth_q != 4'h8) begin
        depth_d = depth_q + 4'h1;
      end
    end else if (pop && depth_q != 4'h0) begin
      ptr_d = ptr_q - 3'h1;
      depth_d = depth_q - 4'h1;
    end
  end

  // contents are kept through reset and sleep
  always_ff @(posedge aclk) begin
    mem_q <= mem_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr_q <= 3'h0;
      depth_q <= 4'h0;
    end else begin
      ptr_q <= ptr_d;
      depth_q <= depth_d;
    end
  end

  assign top = mem_q[ptr_q - 3'h1];
  assign depth = depth_q;
endmodule
`default_nettype wire

// >>> design/shadow_bank.sv
// single-level shadow copies of the eleven core registers
`timescale 1ns/1ps
`default_nettype none
`include "intc_defines.svh"
module shadow_bank (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic save,
  input wire logic restore,
  // register image
  input wire logic [`IC_SHADOW_REGS*16-1:0] live_regs,
  output logic [`IC_SHADOW_REGS*16-1:0] saved_regs,
  output logic restore_valid
);
  logic restore_q, restore_d;

  for (genvar i = 0; i < `IC_SHADOW_REGS; i++) begin : g_reg
    logic [15:0] sh_q, sh_d;
    always_comb begin
      sh_d = sh_q;
      if (save) begin
        sh_d = live_regs[i*16 +: 16]; // R10
      end
    end
    always_ff @(posedge aclk) begin
      sh_q <= sh_d;
    end
    assign saved_regs[i*16 +: 16] = sh_q;
  end

  always_comb begin
    restore_d = restore; // R11
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      restore_q <= 1'b0;
    end else begin
      restore_q <= restore_d;
    end
  end

  assign restore_valid = restore_q;
endmodule
`default_nettype wire

// >>> design/intc_top.sv
// interrupt arbitration, vectoring and power-down control for the core
// How it works
// (R1) four external lines, reset and nmi in
// (R2) serial, timer and soft calls raise requests
// (R3) reset, then nmi, external line four last
// (R4) mask bit per source except reset, nmi
// (R5) flag bit per source, software set/clear/test
// (R6) vector slots two words apart
// (R7) table at zero, movable by 2K page
// (R8) no take during multicycle instruction
// (R9) pc pushed on eight-deep return stack
// (R10) eleven core registers shadowed on take
// (R11) either interrupt return restores shadows
// (R12) sleep via idle instructions or hold low
// (R13) hold sleep keeps peripherals, ends on release
// (R14) all state kept while asleep
// (R15) light idle halts core, clock out runs
// (R16) light idle ends on any interrupt
// (R17) deep idle stops core and peripherals
// (R18) deep wake needs pin low five cycles
// (R19) flag set on request, cleared when taken
// (R20) stack overflow drops the oldest entry
//
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "intc_defines.svh"
module intc_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // request pins, active low
  input wire logic [3:0] ext_request_lines_n,
  input wire logic reset_line_n,
  input wire logic nmi_n,
  input wire logic hold_n,
  // peripheral events
  input wire logic serial_rx_event,
  input wire logic serial_tx_event,
  input wire logic timer_event,
  // core side
  input wire logic instr_busy,
  input wire logic [15:0] core_pc,
  input wire logic call_push,
  input wire logic sub_return,
  input wire logic return_enable_instr,
  input wire logic return_plain_instr,
  input wire logic vectored_soft_call,
  input wire logic [4:0] soft_slot,
  input wire logic idle_instr,
  input wire logic deep_sleep_instr,
  input wire logic [`IC_SHADOW_REGS*16-1:0] core_regs,
  // to the core
  output logic core_reset,
  output logic int_take,
  output logic [15:0] int_vector,
  output logic [15:0] return_pc,
  output logic return_valid,
  output logic restore_valid,
  output logic [`IC_SHADOW_REGS*16-1:0] restore_regs,
  output logic core_halt,
  output logic periph_run,
  output logic machine_clock_out_en
);
  // pin synchronisers: reset, nmi, ext_request_lines, hold
  logic [6:0] pin_s1_q, pin_s2_q, pin_prev_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_q <= 7'h7F;
      pin_s2_q <= 7'h7F;
      pin_prev_q <= 7'h7F;
    end else begin
      pin_s1_q <= {hold_n, nmi_n, reset_line_n, ext_request_lines_n};
      pin_s2_q <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end

  logic [3:0] ext_low;
  logic rst_low, nmi_low, hold_low;
  assign ext_low = ~pin_s2_q[3:0]; // R1
  assign rst_low = ~pin_s2_q[4];
  assign nmi_low = ~pin_s2_q[5];
  assign hold_low = ~pin_s2_q[6];

  // falling edges of the request lines
  logic [3:0] ext_fall;
  logic nmi_fall;
  assign ext_fall = pin_prev_q[3:0] & ~pin_s2_q[3:0];
  assign nmi_fall = pin_prev_q[5] & ~pin_s2_q[5];

  // registers and control state
  logic [6:0] mask_q, mask_d, flag_q, flag_d;
  logic [4:0] base_q, base_d;
  logic intm_q, intm_d, nmi_pend_q, nmi_pend_d;
  intc_pkg::power_state_t ps_q, ps_d;
  logic [2:0] wake_cnt_q, wake_cnt_d;
  logic take_q, take_d, rst_q, rst_d, ret_q, ret_d;
  logic [15:0] vec_q, vec_d, ret_pc_q, ret_pc_d;
  logic push, pop, save, restore;
  logic [15:0] stack_top;
  logic [3:0] stack_depth;

  // axi state
  logic aw_held_q, aw_held_d, w_held_q, w_held_d;
  logic [7:0] waddr_q, waddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic do_wr;

  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign do_wr = aw_held_q && w_held_q && !bvalid_q;

  // merge a register write with byte strobes on the low half
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [15:0] r;
    r = old;
    if (strb[0]) begin
      r[7:0] = data[7:0];
    end
    if (strb[1]) begin
      r[15:8] = data[15:8];
    end
    return r;
  endfunction

  logic [15:0] wmask, wflag, mode_word, wmode;
  assign wmask = merge({9'h000, mask_q}, wdata_q, wstrb_q);
  assign wflag = merge(16'h0000, wdata_q, wstrb_q);
  assign mode_word = {base_q, 10'h000, intm_q};
  assign wmode = merge(mode_word, wdata_q, wstrb_q);

  // bus side of the register file
  always_comb begin
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_d = 1'b1;
      waddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (do_wr) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      if (waddr_q == `IC_OFF_MASK || waddr_q == `IC_OFF_FLAG ||
          waddr_q == `IC_OFF_FLAG_SET || waddr_q == `IC_OFF_FLAG_CLR ||
          waddr_q == `IC_OFF_MODE || waddr_q == `IC_OFF_STATUS) begin
        bresp_d = `IC_RESP_OKAY;
      end else begin
        bresp_d = `IC_RESP_SLVERR;
      end
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d = `IC_RESP_OKAY;
      rdata_d = 32'h0000_0000;
      if (s_axi_araddr == `IC_OFF_MASK) begin
        rdata_d[6:0] = mask_q;
      end else if (s_axi_araddr == `IC_OFF_FLAG) begin
        rdata_d[6:0] = flag_q; // R5
      end else if (s_axi_araddr == `IC_OFF_FLAG_SET ||
                   s_axi_araddr == `IC_OFF_FLAG_CLR) begin
        rdata_d[6:0] = 7'h00;
      end else if (s_axi_araddr == `IC_OFF_MODE) begin
        rdata_d[15:0] = mode_word;
      end else if (s_axi_araddr == `IC_OFF_STATUS) begin
        rdata_d[1:0] = ps_q;
        rdata_d[7:4] = stack_depth;
        rdata_d[8] = nmi_pend_q;
      end else begin
        rresp_d = `IC_RESP_SLVERR;
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  // interrupt and power-down core
  logic [6:0] src_set, sw_set, sw_clr, taken_bit, ready_bits;
  logic take_ok, any_int;
  logic [4:0] slot;
  always_comb begin
    // peripherals are frozen in deep idle
    src_set = {ext_fall[3], 3'h0, ext_fall[2:0]}; // R1
    if (ps_q != intc_pkg::ps_deep) begin // R17
      src_set[`IC_BIT_TIMER] = timer_event; // R2
      src_set[`IC_BIT_RX] = serial_rx_event; // R2
      src_set[`IC_BIT_TX] = serial_tx_event; // R2
    end
    sw_set = 7'h00;
    sw_clr = 7'h00;
    mask_d = mask_q;
    base_d = base_q;
    intm_d = intm_q;
    if (do_wr) begin
      if (waddr_q == `IC_OFF_MASK) begin
        mask_d = wmask[6:0]; // R4
      end else if (waddr_q == `IC_OFF_FLAG_SET) begin
        sw_set = wflag[6:0]; // R5
      end else if (waddr_q == `IC_OFF_FLAG_CLR) begin
        sw_clr = wflag[6:0]; // R5
      end else if (waddr_q == `IC_OFF_MODE) begin
        base_d = wmode[15:11]; // R7
        intm_d = wmode[0];
      end
    end
    // lowest flag index wins; int4 sits at the top index
    ready_bits = flag_q & mask_q & {7{!intm_q}}; // R4
    taken_bit = 7'h00;
    slot = `IC_SLOT_NMI;
    for (int i = `IC_NSRC - 1; i >= 0; i--) begin
      if (ready_bits[i]) begin
        taken_bit = 7'h01 << i; // R3
        slot = `IC_SLOT_FIRST + 5'(i);
      end
    end
    any_int = nmi_pend_q || (flag_q & mask_q) != 7'h00;
    take_ok = ps_q == intc_pkg::ps_run && !instr_busy && !rst_q; // R8
    take_d = 1'b0;
    vec_d = vec_q;
    push = 1'b0;
    pop = 1'b0;
    save = 1'b0;
    restore = 1'b0;
    nmi_pend_d = nmi_pend_q || nmi_fall;
    if (take_ok && nmi_pend_q) begin
      // nmi outranks every maskable flag and ignores intm
      take_d = 1'b1; // R3
      taken_bit = 7'h00;
      nmi_pend_d = nmi_fall;
      vec_d = {base_q, 11'h000} | {10'h000, `IC_SLOT_NMI, 1'b0}; // R6
    end else if (take_ok && ready_bits != 7'h00) begin
      take_d = 1'b1; // R19
      vec_d = {base_q, 11'h000} | {10'h000, slot, 1'b0}; // R6 R7
    end else if (take_ok && vectored_soft_call) begin
      take_d = 1'b1; // R2
      taken_bit = 7'h00;
      vec_d = {base_q, 11'h000} | {10'h000, soft_slot, 1'b0};
    end else begin
      taken_bit = 7'h00;
    end
    if (take_d) begin
      push = 1'b1; // R9
      save = 1'b1; // R10
      intm_d = 1'b1;
    end else if (ps_q == intc_pkg::ps_run && call_push) begin
      push = 1'b1; // R9
    end else if (ps_q == intc_pkg::ps_run && (sub_return ||
                 return_enable_instr || return_plain_instr)) begin
      pop = 1'b1;
      restore = return_enable_instr || return_plain_instr; // R11
      if (return_enable_instr) begin
        intm_d = 1'b0;
      end
    end
    // a new request beats a clear in the same cycle
    flag_d = (flag_q & ~(sw_clr | taken_bit)) | src_set | sw_set; // R19
    ret_d = pop;
    ret_pc_d = pop ? stack_top : ret_pc_q;
    ps_d = ps_q;
    wake_cnt_d = 3'h0;
    case (ps_q)
      intc_pkg::ps_run: begin
        if (hold_low) begin
          ps_d = intc_pkg::ps_hold; // R12
        end else if (deep_sleep_instr && !take_d) begin
          ps_d = intc_pkg::ps_deep; // R12 R17
        end else if (idle_instr && !take_d) begin
          ps_d = intc_pkg::ps_idle; // R12 R15
        end
      end
      intc_pkg::ps_idle: begin
        if (any_int) begin
          ps_d = intc_pkg::ps_run; // R16
        end
      end
      intc_pkg::ps_deep: begin
        if (rst_low || nmi_low || ext_low != 4'h0) begin
          wake_cnt_d = wake_cnt_q + 3'h1;
        end
        if (wake_cnt_d >= 3'(`IC_WAKE_CYC)) begin
          ps_d = intc_pkg::ps_run; // R18
        end
      end
      intc_pkg::ps_hold: begin
        if (!hold_low) begin
          ps_d = intc_pkg::ps_run; // R13
        end
      end
      default: ps_d = intc_pkg::ps_run;
    endcase
    rst_d = rst_low; // R3
    if (rst_low) begin
      // reset outranks all: flags dropped, table back at zero
      flag_d = 7'h00;
      nmi_pend_d = 1'b0;
      mask_d = `IC_MASK_RESET;
      base_d = `IC_BASE_RESET;
      intm_d = 1'b1;
      take_d = 1'b0;
      ps_d = intc_pkg::ps_run;
    end
  end

  // state is only replaced by a next value, never cleared by sleep
  always_ff @(posedge aclk) begin // R14
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      waddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `IC_RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= `IC_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      mask_q <= `IC_MASK_RESET;
      flag_q <= 7'h00;
      base_q <= `IC_BASE_RESET;
      intm_q <= 1'b1;
      nmi_pend_q <= 1'b0;
      ps_q <= intc_pkg::ps_run;
      wake_cnt_q <= 3'h0;
      take_q <= 1'b0;
      rst_q <= 1'b0;
      ret_q <= 1'b0;
      vec_q <= 16'h0000;
      ret_pc_q <= 16'h0000;
    end else begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      mask_q <= mask_d;
      flag_q <= flag_d;
      base_q <= base_d;
      intm_q <= intm_d;
      nmi_pend_q <= nmi_pend_d;
      ps_q <= ps_d;
      wake_cnt_q <= wake_cnt_d;
      take_q <= take_d;
      rst_q <= rst_d;
      ret_q <= ret_d;
      vec_q <= vec_d;
      ret_pc_q <= ret_pc_d;
    end
  end

  ret_stack u_stack (
    .aclk(aclk),
    .aresetn(aresetn),
    .push(push),
    .pop(pop),
    .push_data(core_pc),
    .top(stack_top),
    .depth(stack_depth)
  );

  shadow_bank u_shadow (
    .aclk(aclk),
    .aresetn(aresetn),
    .save(save),
    .restore(restore),
    .live_regs(core_regs),
    .saved_regs(restore_regs),
    .restore_valid(restore_valid)
  );

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign core_reset = rst_q;
  assign int_take = take_q;
  assign int_vector = vec_q;
  assign return_pc = ret_pc_q;
  assign return_valid = ret_q;
  assign core_halt = ps_q != intc_pkg::ps_run; // R15
  assign periph_run = ps_q != intc_pkg::ps_deep; // R13 R17
  assign machine_clock_out_en = ps_q != intc_pkg::ps_deep; // R15
endmodule
`default_nettype wire

// >>> tb/intc_monitor.sv
// assertions on the interrupt unit's core-side ports
`timescale 1ns/1ps
`default_nettype none
`include "intc_defines.svh"
module intc_monitor (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // inputs of the unit
  input wire logic hold_n,
  input wire logic instr_busy,
  input wire logic return_enable_instr,
  input wire logic return_plain_instr,
  input wire logic [`IC_SHADOW_REGS*16-1:0] core_regs,
  // outputs of the unit
  input wire logic core_reset,
  input wire logic int_take,
  input wire logic [15:0] int_vector,
  input wire logic restore_valid,
  input wire logic [`IC_SHADOW_REGS*16-1:0] restore_regs,
  input wire logic core_halt,
  input wire logic periph_run,
  input wire logic machine_clock_out_en
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_vector_slot: assert property (
    int_take |-> int_vector[10:6] == 5'h00 && !int_vector[0])
    else $error("vector off its two-word slot");
  a_busy_defers: assert property (
    int_take |-> !$past(instr_busy))
    else $error("take during a multicycle instruction");
  a_shadow_copy: assert property (
    int_take |-> restore_regs == $past(core_regs))
    else $error("shadow copy differs from core registers");
  a_restore_cause: assert property (
    restore_valid |-> $past(return_enable_instr || return_plain_instr))
    else $error("restore without a return");
  a_reset_quiet: assert property (core_reset |=> !int_take)
    else $error("take while reset pin active");
  a_deep_halt: assert property (
    !periph_run |-> core_halt && !machine_clock_out_en)
    else $error("peripherals stopped outside deep idle");
  a_idle_clock: assert property (
    core_halt && periph_run |-> machine_clock_out_en)
    else $error("clock output stopped in light sleep");
  // five cycles of margin cover the pin synchroniser
  a_hold_sleep: assert property (
    $fell(hold_n) ##1 !hold_n [*5] |-> core_halt || core_reset)
    else $error("hold low did not halt the core");
  c_take: cover property (int_take);
  c_restore: cover property (restore_valid);
  c_deep: cover property (!periph_run);
endmodule
bind intc_top intc_monitor u_mon (.aclk, .aresetn, .hold_n, .instr_busy,
  .return_enable_instr, .return_plain_instr, .core_regs, .core_reset,
  .int_take, .int_vector, .restore_valid, .restore_regs, .core_halt,
  .periph_run, .machine_clock_out_en);
`default_nettype wire

// >>> tb/pin_model.sv
// outside devices on the request, hold and reset pins
`timescale 1ns/1ps
`default_nettype none
module pin_model (
  // clock
  input wire logic aclk,
  // pins, pulled up while released
  output logic [3:0] ext_request_lines_n,
  output logic nmi_n,
  output logic hold_n,
  output logic reset_line_n
);
  logic [6:0] pin_low = 7'h00;
  assign {reset_line_n, hold_n, nmi_n, ext_request_lines_n} = ~pin_low;
  // pin w low for n cycles; 0..3 lines, 4 nmi, 5 hold, 6 reset
  task drive(input int w, input int n);
    @(posedge aclk);
    pin_low[w] <= 1'b1;
    repeat (n) @(posedge aclk);
    pin_low <= 7'h00;
  endtask
endmodule
`default_nettype wire

// >>> tb/intc_top_tb.sv
// random and directed bench for the interrupt and power-down unit
`timescale 1ns/1ps
`default_nettype none
`include "intc_defines.svh"
module intc_top_tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, reset_line_n, nmi_n;
  logic hold_n, serial_rx_event, serial_tx_event, timer_event, instr_busy;
  logic call_push, sub_return, return_enable_instr, return_plain_instr;
  logic vectored_soft_call, idle_instr, deep_sleep_instr, core_reset;
  logic int_take, return_valid, restore_valid, core_halt, periph_run;
  logic machine_clock_out_en;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb, ext_request_lines_n;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [4:0] soft_slot, s;
  logic [6:0] f, m;
  logic [9:0] pulses;
  logic [15:0] core_pc, int_vector, return_pc, last_vec;
  logic [`IC_SHADOW_REGS*16-1:0] core_regs, restore_regs, saved;
  logic [15:0] pops[$];
  int err_total, comparisons, takes, t0;

  intc_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ext_request_lines_n, .reset_line_n, .nmi_n, .hold_n, .serial_rx_event,
    .serial_tx_event, .timer_event, .instr_busy, .core_pc, .call_push,
    .sub_return, .return_enable_instr, .return_plain_instr,
    .vectored_soft_call, .soft_slot, .idle_instr, .deep_sleep_instr,
    .core_regs, .core_reset, .int_take, .int_vector, .return_pc,
    .return_valid, .restore_valid, .restore_regs, .core_halt, .periph_run,
    .machine_clock_out_en);
  pin_model u_pins (.aclk, .ext_request_lines_n, .nmi_n, .hold_n,
    .reset_line_n);

  assign {return_enable_instr, serial_tx_event, serial_rx_event, timer_event,
    vectored_soft_call, deep_sleep_instr, idle_instr, return_plain_instr,
    sub_return, call_push} = pulses;

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // pulses are caught on the edge so none is missed between polls
  always @(posedge aclk) begin
    if (int_take === 1'b1) begin
      takes++;
      last_vec = int_vector;
    end
    if (return_valid === 1'b1) pops.push_back(return_pc);
  end

  task check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task stop_test;
    if (err_total == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // one write (we=1) or read; handshakes sampled mid-cycle, released at edge
  task bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    logic ah, wh, ar, done;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{we}};
    {s_axi_arvalid, s_axi_rready} <= {2{!we}};
    done = 1'b0;
    while (!done) begin
      @(negedge aclk);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      ar = s_axi_arvalid && s_axi_arready;
      done = we ? s_axi_bvalid : s_axi_rvalid;
      {rd, rsp} = we ? {32'h0, s_axi_bresp} : {s_axi_rdata, s_axi_rresp};
      @(posedge aclk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
      if (ar) s_axi_arvalid <= 1'b0;
    end
    {s_axi_bready, s_axi_rready} <= 2'b00;
  endtask

  task strobe(input int w);
    @(posedge aclk);
    pulses <= 10'h001 << w;
    @(posedge aclk);
    pulses <= 10'h000;
  endtask

  task wait_take(input logic [15:0] vec);
    repeat (30) if (takes == t0) @(negedge aclk);
    check(32'(takes - t0), 32'h1);
    check({16'h0, last_vec}, {16'h0, vec});
  endtask

  task wait_halt(input logic v);
    repeat (15) if (core_halt !== v) @(negedge aclk);
    check({31'h0, core_halt}, {31'h0, v});
  endtask

  // table placed on page 3 throughout
  function automatic logic [15:0] vec_of(input logic [4:0] slot);
    return {5'h03, 5'h00, slot, 1'b0};
  endfunction

  function automatic logic [4:0] first_slot(input logic [6:0] v);
    first_slot = 5'h00;
    for (int i = 6; i >= 0; i--) if (v[i]) first_slot = 5'(i + 1);
  endfunction

  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, core_pc, soft_slot} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, instr_busy, pulses, core_regs, aresetn} = '0;
    s_axi_wstrb = 4'hF;
    void'($urandom(79));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    bus(0, `IC_OFF_MODE, 0);
    check(rd, 32'h1);
    bus(0, `IC_OFF_MASK, 0);
    check(rd, 32'h0);
    bus(0, 8'h18, 0);
    check({rd[29:0], rsp}, {30'h0, `IC_RESP_SLVERR});
    bus(1, 8'h18, 0);
    check({30'h0, rsp}, {30'h0, `IC_RESP_SLVERR});
    for (int i = 6; i < 9; i++) strobe(i);
    for (int i = 0; i < 4; i++) u_pins.drive(i, 4);
    bus(0, `IC_OFF_FLAG, 0);
    check(rd, 32'h7F);
    for (int n = 0; n < 12; n++) begin
      f = 7'($urandom_range(1, 127));
      m = (n == 0) ? 7'h7F : 7'($urandom);
      bus(1, `IC_OFF_FLAG_CLR, 32'h7F);
      bus(1, `IC_OFF_MODE, 32'h1801);
      bus(1, `IC_OFF_FLAG_SET, {25'h0, f});
      bus(0, `IC_OFF_FLAG, 0);
      check(rd, {25'h0, f});
      bus(1, `IC_OFF_MASK, {25'h0, m});
      t0 = takes;
      s = first_slot(f & m);
      bus(1, `IC_OFF_MODE, 32'h1800);
      if (s != 5'h00) begin
        wait_take(vec_of(s));
        bus(0, `IC_OFF_FLAG, 0);
        check(rd, {25'h0, f & ~(7'h01 << (s - 5'h01))});
      end else begin
        repeat (10) @(negedge aclk);
        check(32'(takes - t0), 32'h0);
      end
    end
    bus(1, `IC_OFF_MODE, 32'h1801);
    bus(1, `IC_OFF_FLAG_CLR, 32'h7F);
    bus(1, `IC_OFF_FLAG_SET, 32'h40);
    bus(1, `IC_OFF_MASK, 32'h7F);
    instr_busy <= 1'b1;
    t0 = takes;
    bus(1, `IC_OFF_MODE, 32'h1800);
    repeat (10) @(negedge aclk);
    check(32'(takes - t0), 32'h0);
    @(posedge aclk);
    instr_busy <= 1'b0;
    wait_take(vec_of(5'h07));
    t0 = takes;
    u_pins.drive(4, 3);
    wait_take(vec_of(`IC_SLOT_NMI));
    @(posedge aclk);
    for (int i = 0; i < `IC_SHADOW_REGS; i++)
      core_regs[16*i +: 16] <= 16'($urandom);
    soft_slot <= 5'h09;
    t0 = takes;
    strobe(5);
    wait_take(vec_of(5'h09));
    saved = core_regs;
    @(posedge aclk);
    core_regs <= ~saved;
    strobe(9);
    @(negedge aclk);
    check({31'h0, restore_valid}, 32'h1);
    check(32'(restore_regs === saved), 32'h1);
    repeat (8) strobe(1);
    repeat (2) @(posedge aclk);
    pops.delete();
    for (int k = 1; k <= 9; k++) begin
      core_pc <= 16'(k);
      strobe(0);
    end
    repeat (8) strobe(1);
    repeat (2) @(negedge aclk);
    check(32'(pops.size()), 32'h8);
    for (int k = 0; k < 8; k++) check({16'h0, pops[k]}, 32'(9 - k));
    bus(1, `IC_OFF_MASK, 32'h08);
    strobe(3);
    bus(0, `IC_OFF_STATUS, 0);
    check({30'h0, rd[1:0]}, {30'h0, intc_pkg::ps_idle});
    check({30'h0, core_halt, machine_clock_out_en}, 32'h3);
    strobe(6);
    wait_halt(1'b0);
    bus(1, `IC_OFF_FLAG_CLR, 32'h7F);
    strobe(4);
    wait_halt(1'b1);
    check({31'h0, periph_run}, 32'h0);
    u_pins.drive(0, 3);
    repeat (10) @(negedge aclk);
    check({31'h0, core_halt}, 32'h1);
    u_pins.drive(0, 7);
    wait_halt(1'b0);
    fork
      u_pins.drive(5, 12);
      begin
        wait_halt(1'b1);
        check({31'h0, periph_run}, 32'h1);
      end
    join
    wait_halt(1'b0);
    u_pins.drive(6, 6);
    @(negedge aclk);
    check({31'h0, core_reset}, 32'h1);
    repeat (5) @(posedge aclk);
    bus(0, `IC_OFF_MASK, 0);
    check(rd, 32'h0);
    check({31'h0, core_reset}, 32'h0);
    stop_test;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    stop_test;
  end
endmodule
`default_nettype wire
